// [verilog/fwm_cycle_pkg.sv]
// constants and carrier types for the firmware memory cycle target
// assumes a single 100 MHz clock domain and a 4-bit nibble bus
package fwm_cycle_pkg;

  // start field codes
  localparam logic [3:0] START_READ   = 4'hd;
  localparam logic [3:0] START_WRITE  = 4'he;

  // fixed nibble values driven or expected on the bus
  localparam logic [3:0] NIB_ONES     = 4'hf;
  localparam logic [3:0] SYNC_READY   = 4'h0;

  // transfer size codes
  localparam logic [3:0] SIZE_1B      = 4'h0;
  localparam logic [3:0] SIZE_2B      = 4'h1;
  localparam logic [3:0] SIZE_4B      = 4'h2;
  localparam logic [3:0] SIZE_16B     = 4'h4;
  localparam logic [3:0] SIZE_128B    = 4'h7;

  // address field: seven nibbles, index of the last one
  localparam logic [7:0] ADDR_LAST    = 8'h06;
  localparam int         ADDR_W       = 28;
  localparam int         ADDR_CORE    = 22;
  localparam int         ADDR_LOW_W   = 21;

  // counter helpers
  localparam logic [7:0] CNT_ZERO     = 8'h00;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  localparam logic [8:0] NIB_BASE     = 9'h002;
  localparam logic [8:0] NIB_DEC      = 9'h001;
  localparam logic [7:0] BYTE_BASE    = 8'h01;

  // bus cycle phases, one-hot
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_SIZE  = 9'h004,
    ST_WDATA = 9'h008,
    ST_HTAR0 = 9'h010,
    ST_HTAR1 = 9'h020,
    ST_SYNC  = 9'h040,
    ST_RDATA = 9'h080,
    ST_DTAR  = 9'h100
  } phase_type;

  // request handed to the memory side at ready sync
  typedef struct packed {
    logic                  write;
    logic                  core;
    logic [ADDR_LOW_W-1:0] addr;
    logic [3:0]            size;
    logic [31:0]           data;
  } mem_req_type;

endpackage : fwm_cycle_pkg

// [verilog/fwm_cycle_target.sv]
// nibble-bus target for firmware memory read and write cycles
// assumes frame, nibble bus and strap pins arrive asynchronously; the
// memory side answers read bytes combinationally from RD_ADDR
//
// Function
// - start 1101 with frame low means read
// - start 1110 means write, decoded as frame rises
// - only last start nibble before frame rises
// - second clock select nibble must match straps
// - seven address nibbles, most significant first
// - read sizes 0,1,2,4,7 only
// - write sizes 0,1,2 only
// - device takes bus in second turnaround clock
// - read sync 0000, data follows next clock
// - read data nibbles, low nibble first
// - after read data drive ones, then float
// - write sync 0000 shows data accepted
// - after write sync drive ones, then float
// - every field sampled on its rising edge
// - frame low mid cycle ends cycle, release
// - abort cancels only the current bus cycle
// - select mismatch: ignore cycle, never drive
// - bad size: back to idle, no response
// - A22 picks core or registers, A0-A20 kept
// - unaligned multi-byte address aligned down
`timescale 1ns/1ps
`default_nettype none

module fwm_cycle_target (
  // clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RESETN,
  // nibble bus pins
  input  wire logic                      LFRAME_N,
  input  wire logic [3:0]                LAD_IN,
  output var  logic [3:0]                LAD_OUT,
  output var  logic                      LAD_OE,
  // strap pins
  input  wire logic [3:0]                STRAP_SELECT_PINS,
  // memory side
  output var  logic                      MEM_STB,
  output var  fwm_cycle_pkg::mem_req_type MEM_REQ,
  output var  logic [20:0]               RD_ADDR,
  input  wire logic [7:0]                RD_DATA
);
  import fwm_cycle_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic        lframe_meta_ff;
  logic        lframe_s_ff;
  logic [3:0]  lad_meta_ff;
  logic [3:0]  lad_s_ff;
  logic [3:0]  strap_meta_ff;
  logic [3:0]  strap_s_ff;
  // whole bus view lags the pins by two clocks, consistently
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lframe_meta_ff <= 1'b1;
      lframe_s_ff    <= 1'b1;
      lad_meta_ff    <= NIB_ONES;
      lad_s_ff       <= NIB_ONES;
      strap_meta_ff  <= 4'h0;
      strap_s_ff     <= 4'h0;
    end else begin
      lframe_meta_ff <= LFRAME_N;
      lframe_s_ff    <= lframe_meta_ff;
      lad_meta_ff    <= LAD_IN;
      lad_s_ff       <= lad_meta_ff;
      strap_meta_ff  <= STRAP_SELECT_PINS;
      strap_s_ff     <= strap_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // start field capture
  // ----------------------------------------------------------------
  logic        frame_low_ff;
  logic [3:0]  start_ff;
  logic        dir_write_ff;
  // each low clock overwrites, so the last nibble before release wins
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      frame_low_ff <= 1'b0;
      start_ff     <= NIB_ONES;
    end else begin
      frame_low_ff <= !lframe_s_ff;
      if (!lframe_s_ff) begin
        start_ff <= lad_s_ff;
      end
    end
  end
  logic start_known;
  logic select_hit;
  assign start_known = frame_low_ff &&
                       (start_ff == START_READ ||
                        start_ff == START_WRITE);
  assign select_hit  = (lad_s_ff == strap_s_ff);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dir_write_ff <= 1'b0;
    end else if (lframe_s_ff && start_known) begin
      dir_write_ff <= (start_ff == START_WRITE);
    end
  end

  // ----------------------------------------------------------------
  // phase sequencing
  // ----------------------------------------------------------------
  phase_type   state_ff;
  phase_type   nxt_state;
  logic [7:0]  cnt_ff;
  logic [3:0]  size_ff;
  logic [7:0]  nib_last;
  logic        size_ok;
  // writes stop at four bytes, reads also take 16 and 128
  assign size_ok  = (lad_s_ff == SIZE_1B) || (lad_s_ff == SIZE_2B) ||
                    (lad_s_ff == SIZE_4B) ||
                    (!dir_write_ff && (lad_s_ff == SIZE_16B ||
                                       lad_s_ff == SIZE_128B));
  // two nibbles per byte, 2**size bytes
  assign nib_last = 8'((NIB_BASE << size_ff[2:0]) - NIB_DEC);
  always_comb begin
    nxt_state = state_ff;
    if (!lframe_s_ff) begin
      // frame low aborts whatever runs; an abort nibble changes nothing
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // mismatch stays idle: frame_low_ff drops, no retrigger
          if (start_known && select_hit) begin
            nxt_state = ST_ADDR;
          end
        end
        ST_ADDR: begin
          if (cnt_ff == ADDR_LAST) begin
            nxt_state = ST_SIZE;
          end
        end
        ST_SIZE: begin
          if (!size_ok) begin
            nxt_state = ST_IDLE;
          end else if (dir_write_ff) begin
            nxt_state = ST_WDATA;
          end else begin
            nxt_state = ST_HTAR0;
          end
        end
        ST_WDATA: begin
          if (cnt_ff == nib_last) begin
            nxt_state = ST_HTAR0;
          end
        end
        ST_HTAR0: begin
          // host ones then float, nothing to sample
          nxt_state = ST_HTAR1;
        end
        ST_HTAR1: begin
          nxt_state = ST_SYNC;
        end
        ST_SYNC: begin
          nxt_state = dir_write_ff ? ST_DTAR : ST_RDATA;
        end
        ST_RDATA: begin
          if (cnt_ff == nib_last) begin
            nxt_state = ST_DTAR;
          end
        end
        ST_DTAR: begin
          nxt_state = ST_IDLE;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_ff <= CNT_ZERO;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= CNT_ZERO;
    end else if (state_ff == ST_ADDR || state_ff == ST_WDATA ||
                 state_ff == ST_RDATA) begin
      cnt_ff <= cnt_ff + CNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // address, size and write data capture
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]     addr_ff;
  logic [31:0]           wdata_ff;
  logic [7:0]            byte_mask;
  logic [ADDR_LOW_W-1:0] base_addr;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      addr_ff  <= '0;
      size_ff  <= SIZE_1B;
      wdata_ff <= '0;
    end else begin
      if (state_ff == ST_ADDR) begin
        addr_ff <= {addr_ff[ADDR_W-5:0], lad_s_ff};
      end
      if (state_ff == ST_SIZE) begin
        size_ff <= lad_s_ff;
      end
      if (state_ff == ST_WDATA) begin
        wdata_ff[{cnt_ff[2:0], 2'b00} +: 4] <= lad_s_ff;
      end
    end
  end
  // only A0..A20 and A22 are decoded; the page base is forced
  assign byte_mask = 8'((BYTE_BASE << size_ff[2:0]) - BYTE_BASE);
  assign base_addr = addr_ff[ADDR_LOW_W-1:0] &
                     ~{13'h0000, byte_mask};

  // ----------------------------------------------------------------
  // memory side request and read address
  // ----------------------------------------------------------------
  logic enter_sync;
  logic nxt_low;
  assign enter_sync = (state_ff == ST_HTAR1) && (nxt_state == ST_SYNC);
  assign nxt_low    = (state_ff == ST_SYNC) || cnt_ff[0];
  // requests issue only at sync, so a cycle aborted before sync leaves no trace
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      MEM_STB <= 1'b0;
      MEM_REQ <= '0;
    end else begin
      MEM_STB <= enter_sync;
      if (enter_sync) begin
        MEM_REQ.write <= dir_write_ff;
        MEM_REQ.core  <= addr_ff[ADDR_CORE];
        MEM_REQ.addr  <= base_addr;
        MEM_REQ.size  <= size_ff;
        MEM_REQ.data  <= wdata_ff;
      end
    end
  end
  // advance after the high nibble of each byte leaves
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_ADDR <= '0;
    end else if (enter_sync) begin
      RD_ADDR <= base_addr;
    end else if (nxt_state == ST_RDATA && !nxt_low) begin
      RD_ADDR <= RD_ADDR + 21'h000001;
    end
  end

  // ----------------------------------------------------------------
  // bus drive
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LAD_OUT <= NIB_ONES;
      LAD_OE  <= 1'b0;
    end else begin
      case (nxt_state)
        ST_HTAR1: begin
          LAD_OUT <= NIB_ONES;
          LAD_OE  <= 1'b1;
        end
        ST_SYNC: begin
          LAD_OUT <= SYNC_READY;
          LAD_OE  <= 1'b1;
        end
        ST_RDATA: begin
          LAD_OUT <= nxt_low ? RD_DATA[3:0] : RD_DATA[7:4];
          LAD_OE  <= 1'b1;
        end
        ST_DTAR: begin
          LAD_OUT <= NIB_ONES;
          LAD_OE  <= 1'b1;
        end
        default: begin
          LAD_OUT <= NIB_ONES;
          LAD_OE  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  a_abort_releases_bus: assert property (
    !lframe_s_ff |=> !LAD_OE && state_ff == ST_IDLE)
    else $error("bus still driven after frame abort");
  a_read_start_decode: assert property (
    state_ff == ST_IDLE && lframe_s_ff && frame_low_ff &&
    start_ff == START_READ && select_hit |=> state_ff == ST_ADDR)
    else $error("read start not decoded");
  a_mismatch_stays_quiet: assert property (
    state_ff == ST_IDLE && lframe_s_ff && !select_hit
    |=> state_ff == ST_IDLE && !LAD_OE [*2])
    else $error("device reacted to foreign select");
  a_address_seven_nibbles: assert property (
    $rose(state_ff == ST_ADDR) ##0 lframe_s_ff [*7]
    |=> state_ff == ST_SIZE)
    else $error("address phase not seven nibbles");
  a_bad_size_idle: assert property (
    state_ff == ST_SIZE && lframe_s_ff && !size_ok
    |=> state_ff == ST_IDLE ##1 !LAD_OE && !MEM_STB)
    else $error("bad size not rejected");
  a_take_over_ones: assert property (
    state_ff == ST_HTAR1 |-> LAD_OE && LAD_OUT == NIB_ONES)
    else $error("no takeover in second turnaround");
  a_sync_then_data: assert property (
    state_ff == ST_SYNC && !dir_write_ff && lframe_s_ff
    |-> LAD_OUT == SYNC_READY && LAD_OE ##1 state_ff == ST_RDATA)
    else $error("read sync or data order wrong");
  a_read_ends_ones: assert property (
    state_ff == ST_RDATA && cnt_ff == nib_last && lframe_s_ff
    |=> LAD_OUT == NIB_ONES && LAD_OE ##1 !LAD_OE)
    else $error("read turnaround wrong");
  a_write_sync_strobe: assert property (
    state_ff == ST_SYNC && dir_write_ff |-> MEM_STB &&
    MEM_REQ.write && LAD_OUT == SYNC_READY)
    else $error("write sync without request");
  a_write_ends_ones: assert property (
    state_ff == ST_SYNC && dir_write_ff && lframe_s_ff
    |=> LAD_OUT == NIB_ONES && LAD_OE ##1 !LAD_OE)
    else $error("write turnaround wrong");
  a_aligned_request: assert property (
    MEM_STB |-> (MEM_REQ.addr[7:0] & byte_mask) == 8'h00)
    else $error("request address not page aligned");
  a_float_elsewhere: assert property (
    state_ff inside {ST_IDLE, ST_ADDR, ST_SIZE, ST_WDATA, ST_HTAR0}
    |-> !LAD_OE)
    else $error("bus driven outside own clocks");
  c_read_single: cover property (
    state_ff == ST_SYNC && !dir_write_ff && size_ff == SIZE_1B);
  c_read_burst: cover property (
    state_ff == ST_DTAR && !dir_write_ff && size_ff == SIZE_128B);
  c_write_dword: cover property (
    state_ff == ST_SYNC && dir_write_ff && size_ff == SIZE_4B);
  c_abort_mid_read: cover property (
    state_ff == ST_RDATA && !lframe_s_ff);

endmodule : fwm_cycle_target

`default_nettype wire

// [tb/fwm_host_model.sv]
// host side model: frames read and write cycles on the nibble bus
// assumes the bench resolves the wire, with a pull-up to ones
`timescale 1ns/1ps
`default_nettype none
module fwm_host_model (
  // bus
  input  wire logic       clk,
  input  wire logic [3:0] lad_wire,
  output var  logic       frame_n,
  output var  logic [3:0] lad,
  output var  logic       lad_en
);
  import fwm_cycle_pkg::*;
  logic [3:0] rx[$];
  bit         synced;
  initial begin
    frame_n = 1'b1;
    lad     = NIB_ONES;
    lad_en  = 1'b0;
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic put(input logic [3:0] v);
    lad = v;
    tick();
  endtask : put
  // ----------------------------------------------------------------
  // one bus cycle; abort_at >= 0 aborts a read after that many data nibbles
  // ----------------------------------------------------------------
  task automatic run(input logic [3:0] pre, start, sel, size,
                     input logic [27:0] addr, input logic [31:0] wd,
                     input int abort_at);
    int nn;
    int k;
    nn = 2 << size;
    rx.delete();
    synced = 0;
    lad_en = 1'b1;
    frame_n = 1'b0;
    put(pre);
    put(start);
    frame_n = 1'b1;
    put(sel);
    for (k = 6; k >= 0; k--) put(addr[4*k +: 4]);
    put(size);
    // a refused size wider than the data word is cut short
    if (start == START_WRITE)
      for (k = 0; k < nn && k < 8; k++) put(wd[4*k +: 4]);
    put(NIB_ONES);
    lad_en = 1'b0;
    for (k = 0; k < 8 && !synced; k++) begin
      tick();
      synced = (lad_wire === SYNC_READY);
    end
    if (synced && start == START_READ)
      for (k = 0; k < nn; k++) begin
        if (k == abort_at) begin
          frame_n = 1'b0;
          lad_en = 1'b1;
          put(NIB_ONES);
          frame_n = 1'b1;
          lad_en = 1'b0;
          break;
        end
        tick();
        rx.push_back(lad_wire);
      end
    if (synced && abort_at < 0) begin
      tick();
      rx.push_back(lad_wire);
    end
    repeat (2) tick();
  endtask : run
endmodule : fwm_host_model
`default_nettype wire

// [tb/fwm_cycle_target_tb_top.sv]
// self-checking bench for the firmware memory cycle target
// assumes the host model above and a memory that answers combinationally
`timescale 1ns/1ps
`default_nettype none
module fwm_cycle_target_tb_top;
  import fwm_cycle_pkg::*;
  logic        clk;
  logic        resetn;
  logic        host_frame_n;
  logic        host_en;
  logic [3:0]  host_lad;
  logic [3:0]  lad_wire;
  logic [3:0]  lad_out;
  logic        lad_oe;
  logic [3:0]  strap;
  logic        mem_stb;
  mem_req_type mem_req;
  mem_req_type req;
  logic [20:0] rd_addr;
  logic [7:0]  rd_data;
  int          err_count;
  int          check_count;
  int          stb_cnt;
  int          oe_cnt;
  int          cyc;
  // pull-up returns the wire to ones whenever nobody drives it
  assign lad_wire = lad_oe ? lad_out : (host_en ? host_lad : NIB_ONES);
  assign rd_data  = rd_addr[7:0] ^ 8'h5a;
  fwm_cycle_target dut (
    .CLK(clk), .RESETN(resetn), .LFRAME_N(host_frame_n),
    .LAD_IN(lad_wire), .LAD_OUT(lad_out), .LAD_OE(lad_oe),
    .STRAP_SELECT_PINS(strap), .MEM_STB(mem_stb), .MEM_REQ(mem_req),
    .RD_ADDR(rd_addr), .RD_DATA(rd_data));
  fwm_host_model host (
    .clk(clk), .lad_wire(lad_wire), .frame_n(host_frame_n),
    .lad(host_lad), .lad_en(host_en));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (resetn && mem_stb) begin
      stb_cnt++;
      req = mem_req;
    end
    if (resetn && lad_oe) oe_cnt++;
    if (cyc == 8000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (err_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic [3:0] pre, start, sel, size,
                      input logic [27:0] addr, input logic [31:0] wd,
                      input int abort_at, input bit resp);
    int          s0;
    int          o0;
    int          nn;
    int          k;
    logic [20:0] base;
    logic [7:0]  b;
    logic [31:0] m;
    s0 = stb_cnt;
    o0 = oe_cnt;
    nn = 2 << size;
    base = addr[20:0] & ~((21'h1 << size) - 21'h1);
    host.run(pre, start, sel, size, addr, wd, abort_at);
    if (abort_at >= 0) begin
      repeat (2) @(posedge clk);
      #1;
      chk(32'(lad_oe), 32'h0);
    end else if (!resp) begin
      chk(32'(stb_cnt - s0), 32'h0);
      chk(32'(oe_cnt - o0), 32'h0);
    end else begin
      chk(32'(host.synced), 32'h1);
      chk(32'(stb_cnt - s0), 32'h1);
      chk(32'(oe_cnt - o0), 32'(start == START_WRITE ? 3 : nn + 3));
      chk(32'(req.write), 32'(start == START_WRITE));
      chk(32'(req.core), 32'(addr[22]));
      chk(32'(req.addr), 32'(base));
      chk(32'(req.size), 32'(size));
      if (start == START_WRITE) begin
        m = (nn == 8) ? 32'hffffffff : (32'h1 << (4 * nn)) - 32'h1;
        chk(req.data & m, wd & m);
        chk(32'(host.rx[0]), 32'(NIB_ONES));
      end else begin
        for (k = 0; k < nn; k++) begin
          b = 8'(base + 21'(k / 2)) ^ 8'h5a;
          chk(32'(host.rx[k]), 32'(k % 2 ? b[7:4] : b[3:0]));
        end
        chk(32'(host.rx[nn]), 32'(NIB_ONES));
      end
    end
  endtask : xfer
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reads;
    logic [3:0] sz[5] = '{SIZE_1B, SIZE_2B, SIZE_4B, SIZE_16B, SIZE_128B};
    foreach (sz[i]) xfer(4'hf, START_READ, 4'h5, sz[i], 28'h9c0123b,
                         32'h0, -1, 1'b1);
  endtask : t_reads
  task automatic t_writes;
    for (int s = 0; s < 3; s++) xfer(4'hf, START_WRITE, 4'h5, 4'(s),
                       28'h0a1234f, 32'hc3a59e17, -1, 1'b1);
  endtask : t_writes
  task automatic t_refused;
    xfer(4'hf, START_READ, 4'ha, SIZE_1B, 28'h0, 32'h0, -1, 1'b0);
    xfer(4'hf, START_READ, 4'h5, 4'h3, 28'h0, 32'h0, -1, 1'b0);
    xfer(4'hf, START_WRITE, 4'h5, SIZE_16B, 28'h0, 32'h0, -1, 1'b0);
    xfer(4'hf, 4'h0, 4'h5, SIZE_1B, 28'h0, 32'h0, -1, 1'b0);
  endtask : t_refused
  task automatic t_last_start;
    xfer(START_WRITE, START_READ, 4'h5, SIZE_2B, 28'h9c0123b,
         32'h0, -1, 1'b1);
  endtask : t_last_start
  task automatic t_abort;
    xfer(4'hf, START_READ, 4'h5, SIZE_4B, 28'h9c0123b, 32'h0, 3, 1'b1);
    xfer(4'hf, START_READ, 4'h5, SIZE_4B, 28'h9c0123b, 32'h0, -1, 1'b1);
  endtask : t_abort
  task automatic t_strap;
    strap = 4'hf;
    repeat (3) @(posedge clk);
    #1;
    xfer(4'hf, START_READ, 4'hf, SIZE_1B, 28'h9c0123b, 32'h0, -1, 1'b1);
    xfer(4'hf, START_READ, 4'h5, SIZE_1B, 28'h9c0123b, 32'h0, -1, 1'b0);
    strap = 4'h5;
  endtask : t_strap
  initial begin
    resetn = 1'b0;
    strap = 4'h5;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_reads();
    t_writes();
    t_refused();
    t_last_start();
    t_abort();
    t_strap();
    report_and_stop();
  end
endmodule : fwm_cycle_target_tb_top
`default_nettype wire
